/* File: dacfz_pkg.sv */
// shared constants for the audio-interface config, readback and zero-detect block
package dacfz_pkg;

  // control word layout
  localparam int CW_W        = 16;
  localparam int CW_RW_BIT   = 15;
  localparam int CW_IDX_HI   = 14;
  localparam int CW_IDX_LO   = 8;
  localparam int CW_DATA_HI  = 7;
  localparam int IDX_W       = 7;
  localparam logic CW_RW_WRITE = 1'b0;
  localparam logic CW_RW_READ  = 1'b1;

  // register indices
  localparam logic [IDX_W-1:0] IDX_MODE_CTRL   = 7'h12;
  localparam logic [IDX_W-1:0] IDX_AUDIO_CFG   = 7'h14;
  localparam logic [IDX_W-1:0] IDX_READ_CTRL   = 7'h15;
  localparam logic [IDX_W-1:0] IDX_WALK_FIRST  = 7'h01;

  // audio_interface_config fields
  localparam int AIC_INTERP_BIT  = 7;
  localparam int AIC_ROLLOFF_HI  = 6;
  localparam int AIC_ROLLOFF_LO  = 5;
  localparam int AIC_HALF_BIT    = 4;
  localparam int AIC_DISABLE_BIT = 3;
  localparam int AIC_FMT_HI      = 2;
  localparam int AIC_FMT_LO      = 0;

  // readback_control fields
  localparam int RBC_INC_BIT     = 7;
  localparam int RBC_TARGET_HI   = 6;

  // mode control register: zero-detect mute enable position
  localparam int MCR_ZMUTE_BIT   = 4;

  // format codes
  localparam logic [2:0] FMT_RJ24    = 3'h0;
  localparam logic [2:0] FMT_RJ20    = 3'h1;
  localparam logic [2:0] FMT_RJ18    = 3'h2;
  localparam logic [2:0] FMT_RJ16    = 3'h3;
  localparam logic [2:0] FMT_I2S     = 3'h4;
  localparam logic [2:0] FMT_JUST    = 3'h5;

  // roll-off codes
  localparam logic [1:0] ROLL_SHARP  = 2'h0;
  localparam logic [1:0] ROLL_SLOW1  = 2'h1;
  localparam logic [1:0] ROLL_SLOW2  = 2'h2;

  // interpolation codes
  localparam logic INTERP_8X = 1'b0;
  localparam logic INTERP_4X = 1'b1;

  // reset values
  localparam logic [2:0]       RST_FMT      = FMT_RJ24;
  localparam logic [1:0]       RST_ROLLOFF  = ROLL_SHARP;
  localparam logic             RST_INTERP   = INTERP_8X;
  localparam logic             RST_CLK_DIS  = 1'b0;
  localparam logic             RST_CLK_HALF = 1'b0;
  localparam logic             RST_INC      = 1'b0;
  localparam logic [IDX_W-1:0] RST_TARGET   = 7'h01;
  localparam logic             RST_ZMUTE    = 1'b0;

  // zero detect
  localparam int ZERO_CNT_W = 10;
  localparam logic [ZERO_CNT_W-1:0] ZERO_LAST = 10'h3FF;
  localparam int SAMPLE_W = 24;

  typedef enum {WALK_IDLE, WALK_RUN} dacfz_walk_t;

endpackage

/* File: dacfz_zd_if.sv */
// carrier between the frame logic and one channel zero detector
`timescale 1ns/10ps
interface dacfz_zd_if;
  logic frame_tick;
  logic sample_zero;
  logic zero_flag;
  modport ctl (output frame_tick, output sample_zero, input zero_flag);
  modport det (input frame_tick, input sample_zero, output zero_flag);
endinterface

/* File: dacfz_zero_det.sv */
// one channel zero detector: flags after 1024 all-zero frames
`timescale 1ns/10ps
module dacfz_zero_det
  import dacfz_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // frame side
  dacfz_zd_if.det   zd
);

  logic [ZERO_CNT_W-1:0] cnt_reg;
  logic                  flag_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (zd.frame_tick) begin
      if (!zd.sample_zero) begin
        cnt_reg <= '0;
      end else if (cnt_reg != ZERO_LAST) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (zd.frame_tick) begin
      if (!zd.sample_zero) begin
        flag_reg <= 1'b0;
      end else if (cnt_reg == ZERO_LAST) begin
        flag_reg <= 1'b1;
      end
    end
  end

  assign zd.zero_flag = flag_reg;

endmodule

/* File: dacfz_top.sv */
// audio config, readback control and per-channel zero detect
`timescale 1ns/10ps

module dacfz_top
  import dacfz_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // control word port
  input  wire logic                ctrl_valid,
  input  wire logic [CW_W-1:0]     ctrl_word,
  output logic                     read_valid,
  output logic [CW_W-1:0]          read_data,
  output logic                     read_busy,
  // audio frame input
  input  wire logic                left_right_clock,
  input  wire logic [SAMPLE_W-1:0] left_sample,
  input  wire logic [SAMPLE_W-1:0] right_sample,
  // configuration to the datapath
  output logic [2:0]               audio_format_sel,
  output logic [1:0]               rolloff_sel,
  output logic                     interp_rate_sel,
  output logic                     clock_out_disable,
  output logic                     clock_out_half_rate,
  output logic                     zero_mute_en,
  output logic                     auto_inc_en,
  output logic [IDX_W-1:0]         word_target_index,
  // clock output pin
  output logic                     clock_out_pin_o,
  output logic                     clock_out_pin_oe,
  // zero detect
  output logic                     left_zero_flag,
  output logic                     right_zero_flag,
  output logic                     left_zero_mute,
  output logic                     right_zero_mute
);

  // request decode
  logic             req_write;
  logic             req_read;
  logic [IDX_W-1:0] req_idx;
  logic [7:0]       req_data;

  assign req_write = ctrl_valid && (ctrl_word[CW_RW_BIT] == CW_RW_WRITE);
  assign req_read  = ctrl_valid && (ctrl_word[CW_RW_BIT] == CW_RW_READ);
  assign req_idx   = ctrl_word[CW_IDX_HI:CW_IDX_LO];
  assign req_data  = ctrl_word[CW_DATA_HI:0];

  // audio interface configuration register
  always_ff @(posedge clk) begin
    if (srst) begin
      audio_format_sel    <= RST_FMT;
      rolloff_sel         <= RST_ROLLOFF;
      interp_rate_sel     <= RST_INTERP;
      clock_out_disable   <= RST_CLK_DIS;
      clock_out_half_rate <= RST_CLK_HALF;
    end else if (req_write && req_idx == IDX_AUDIO_CFG) begin
      interp_rate_sel     <= req_data[AIC_INTERP_BIT];
      rolloff_sel         <= req_data[AIC_ROLLOFF_HI:AIC_ROLLOFF_LO];
      clock_out_half_rate <= req_data[AIC_HALF_BIT];
      clock_out_disable   <= req_data[AIC_DISABLE_BIT];
      audio_format_sel    <= req_data[AIC_FMT_HI:AIC_FMT_LO];
    end
  end

  // readback control register
  always_ff @(posedge clk) begin
    if (srst) begin
      auto_inc_en       <= RST_INC;
      word_target_index <= RST_TARGET;
    end else if (req_write && req_idx == IDX_READ_CTRL) begin
      auto_inc_en       <= req_data[RBC_INC_BIT];
      word_target_index <= req_data[RBC_TARGET_HI:0];
    end
  end

  // mode control register: zero-detect mute enable only
  always_ff @(posedge clk) begin
    if (srst) begin
      zero_mute_en <= RST_ZMUTE;
    end else if (req_write && req_idx == IDX_MODE_CTRL) begin
      zero_mute_en <= req_data[MCR_ZMUTE_BIT];
    end
  end

  // value returned for an index; unheld registers read as zero
  function automatic logic [CW_W-1:0] reg_value(input logic [IDX_W-1:0] idx);
    logic [7:0] data;
    data = 8'h00;
    case (idx)
      IDX_AUDIO_CFG: begin
        data = {interp_rate_sel, rolloff_sel, clock_out_half_rate,
                clock_out_disable, audio_format_sel};
      end
      IDX_READ_CTRL: begin
        data = {auto_inc_en, word_target_index};
      end
      IDX_MODE_CTRL: begin
        data = 8'h00;
        data[MCR_ZMUTE_BIT] = zero_mute_en;
      end
      default: begin
        data = 8'h00;
      end
    endcase
    reg_value = {CW_RW_WRITE, idx, data};
  endfunction

  // readback sequencer
  dacfz_walk_t      walk_state;
  logic [IDX_W-1:0] walk_idx;
  logic             walk_last;

  assign walk_last = (walk_idx == word_target_index) || (walk_idx == {IDX_W{1'b1}});

  always_ff @(posedge clk) begin
    if (srst) begin
      walk_state <= WALK_IDLE;
      walk_idx   <= IDX_WALK_FIRST;
    end else begin
      case (walk_state)
        WALK_IDLE: begin
          if (req_read && auto_inc_en && (word_target_index != IDX_WALK_FIRST)) begin
            walk_state <= WALK_RUN;
            walk_idx   <= IDX_WALK_FIRST + 7'h01;
          end
        end
        WALK_RUN: begin
          if (walk_last) begin
            walk_state <= WALK_IDLE;
            walk_idx   <= IDX_WALK_FIRST;
          end else begin
            walk_idx <= walk_idx + 7'h01;
          end
        end
        default: begin
          walk_state <= WALK_IDLE;
          walk_idx   <= IDX_WALK_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_valid <= 1'b0;
      read_data  <= '0;
    end else if (walk_state == WALK_RUN) begin
      read_valid <= 1'b1;
      read_data  <= reg_value(walk_idx);
    end else if (req_read) begin
      read_valid <= 1'b1;
      if (auto_inc_en) begin
        read_data <= reg_value(IDX_WALK_FIRST);
      end else begin
        read_data <= reg_value(word_target_index);
      end
    end else begin
      read_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_busy <= 1'b0;
    end else if (walk_state == WALK_RUN) begin
      read_busy <= !walk_last;
    end else begin
      read_busy <= req_read && auto_inc_en && (word_target_index != IDX_WALK_FIRST);
    end
  end

  // clock output: full rate toggles each cycle, half rate every other
  logic half_phase;

  always_ff @(posedge clk) begin
    if (srst) begin
      half_phase <= 1'b0;
    end else begin
      half_phase <= !half_phase;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clock_out_pin_o <= 1'b0;
    end else if (!clock_out_half_rate || half_phase) begin
      clock_out_pin_o <= !clock_out_pin_o;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clock_out_pin_oe <= 1'b1;
    end else begin
      clock_out_pin_oe <= !clock_out_disable;
    end
  end

  // frame clock synchroniser and rising-edge tick
  logic left_right_clock_s1;
  logic left_right_clock_s2;
  logic left_right_clock_s3;
  logic frame_tick;

  always_ff @(posedge clk) begin
    if (srst) begin
      left_right_clock_s1 <= 1'b0;
      left_right_clock_s2 <= 1'b0;
      left_right_clock_s3 <= 1'b0;
    end else begin
      left_right_clock_s1 <= left_right_clock;
      left_right_clock_s2 <= left_right_clock_s1;
      left_right_clock_s3 <= left_right_clock_s2;
    end
  end

  assign frame_tick = left_right_clock_s2 && !left_right_clock_s3;

  // per-channel detectors share one counting scheme
  dacfz_zd_if zd_left ();
  dacfz_zd_if zd_right ();

  assign zd_left.frame_tick   = frame_tick;
  assign zd_left.sample_zero  = (left_sample == '0);
  assign zd_right.frame_tick  = frame_tick;
  assign zd_right.sample_zero = (right_sample == '0);

  dacfz_zero_det u_zero_left (
    .clk  (clk),
    .srst (srst),
    .zd   (zd_left.det)
  );

  dacfz_zero_det u_zero_right (
    .clk  (clk),
    .srst (srst),
    .zd   (zd_right.det)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      left_zero_flag  <= 1'b0;
      right_zero_flag <= 1'b0;
    end else begin
      left_zero_flag  <= zd_left.zero_flag;
      right_zero_flag <= zd_right.zero_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      left_zero_mute  <= 1'b0;
      right_zero_mute <= 1'b0;
    end else begin
      left_zero_mute  <= zd_left.zero_flag && zero_mute_en;
      right_zero_mute <= zd_right.zero_flag && zero_mute_en;
    end
  end

endmodule

/* File: dacfz_top_properties.sv */
// port assertions for the config, readback and zero-detect block
`timescale 1ns/10ps
module dacfz_top_properties
  import dacfz_pkg::*;
(
  // clock and reset
  input wire logic             clk,
  input wire logic             srst,
  // control port
  input wire logic             ctrl_valid,
  input wire logic [CW_W-1:0]  ctrl_word,
  input wire logic             read_valid,
  input wire logic [CW_W-1:0]  read_data,
  input wire logic             read_busy,
  // configuration
  input wire logic [2:0]       audio_format_sel,
  input wire logic [1:0]       rolloff_sel,
  input wire logic             interp_rate_sel,
  input wire logic             clock_out_disable,
  input wire logic             clock_out_half_rate,
  input wire logic             zero_mute_en,
  input wire logic             auto_inc_en,
  input wire logic [IDX_W-1:0] word_target_index,
  // pin and zero detect
  input wire logic             clock_out_pin_o,
  input wire logic             clock_out_pin_oe,
  input wire logic             left_zero_flag,
  input wire logic             left_zero_mute
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence wr(logic [6:0] idx);
    ctrl_valid && !ctrl_word[15] && ctrl_word[14:8] == idx;
  endsequence
  sequence rd_taken;
    ctrl_valid && ctrl_word[15] && !read_busy;
  endsequence
  cfg_bits_a: assert property (wr(IDX_AUDIO_CFG) |=>
    {interp_rate_sel, rolloff_sel, clock_out_half_rate, clock_out_disable,
     audio_format_sel} == $past(ctrl_word[7:0])) else $error("config write");
  rbc_write_a: assert property (wr(IDX_READ_CTRL) |=>
    {auto_inc_en, word_target_index} == $past(ctrl_word[7:0])) else $error("readctl write");
  zmute_write_a: assert property (wr(IDX_MODE_CTRL) |=>
    zero_mute_en == $past(ctrl_word[MCR_ZMUTE_BIT])) else $error("mute enable write");
  pin_enable_a: assert property (clock_out_pin_oe == !$past(clock_out_disable))
    else $error("pin enable");
  full_rate_a: assert property ((!clock_out_half_rate && clock_out_pin_oe) [*3] |->
    clock_out_pin_o != $past(clock_out_pin_o)) else $error("full rate");
  half_rate_a: assert property ((clock_out_half_rate && clock_out_pin_oe) [*4] |->
    clock_out_pin_o != $past(clock_out_pin_o, 2)) else $error("half rate");
  mute_on_a: assert property ((left_zero_flag && zero_mute_en) [*2] |->
    left_zero_mute) else $error("zero mute");
  read_single_a: assert property ((rd_taken and !auto_inc_en) |=>
    read_valid && read_data[14:8] == $past(word_target_index)) else $error("single read");
  walk_end_a: assert property (read_valid && !read_busy && !(ctrl_valid && ctrl_word[15])
    |=> !read_valid) else $error("read overrun");
endmodule
bind dacfz_top dacfz_top_properties i_dacfz_top_properties (.*);

/* File: dacfz_host.sv */
// host and audio source model for the control port and frames
`timescale 1ns/10ps
module dacfz_host
  import dacfz_pkg::*;
(
  // clock
  input  wire logic           clk,
  // control port
  output logic                ctrl_valid,
  output logic [CW_W-1:0]     ctrl_word,
  // audio frames
  output logic                left_right_clock,
  output logic [SAMPLE_W-1:0] left_sample,
  output logic [SAMPLE_W-1:0] right_sample
);
  initial begin
    ctrl_valid = 1'b0;
    ctrl_word = 16'h0000;
    left_right_clock = 1'b0;
    left_sample = 24'h000000;
    right_sample = 24'h000000;
  end
  // one strobed word; bus shows inverted data when idle
  task automatic send(input logic [CW_W-1:0] w);
    @(negedge clk);
    ctrl_valid = 1'b1;
    ctrl_word = w;
    @(negedge clk);
    ctrl_valid = 1'b0;
    ctrl_word = ~w;
  endtask
  task automatic frame(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
    left_sample = l;
    right_sample = r;
    left_right_clock = 1'b1;
    repeat (4) @(negedge clk);
    left_right_clock = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

/* File: test_dacfz_top.sv */
// self-checking bench for the config, readback and zero-detect block
`timescale 1ns/10ps
module test_dacfz_top;
  import dacfz_pkg::*;
  logic clk, srst, ctrl_valid, read_valid, read_busy, left_right_clock;
  logic [CW_W-1:0] ctrl_word, read_data;
  logic [SAMPLE_W-1:0] left_sample, right_sample;
  logic [2:0] audio_format_sel;
  logic [1:0] rolloff_sel;
  logic interp_rate_sel, clock_out_disable, clock_out_half_rate, zero_mute_en, auto_inc_en;
  logic [IDX_W-1:0] word_target_index;
  logic clock_out_pin_o, clock_out_pin_oe, left_zero_flag, right_zero_flag;
  logic left_zero_mute, right_zero_mute;
  int fail_count = 0;
  int n_compared = 0;
  // config byte written, then pin toggles over 8 cycles (0 = pin released)
  logic [15:0] rows [6] = '{16'h0008, 16'h2108, 16'h4208, 16'h1B00, 16'h8408, 16'h9504};
  dacfz_top i_dacfz_top (.*);
  dacfz_host i_dacfz_host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic frames(input int n, input logic [SAMPLE_W-1:0] l);
    repeat (n) i_dacfz_host.frame(l, 24'h000001);
  endtask
  initial begin
    int k, t, tog;
    logic p;
    logic [7:0] d;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk({audio_format_sel, rolloff_sel, interp_rate_sel, clock_out_half_rate,
         clock_out_disable, zero_mute_en, auto_inc_en} === 10'h000, "reset");
    chk(clock_out_pin_oe === 1'b1 && word_target_index === 7'h01, "reset pin");
    i_dacfz_host.send(16'h8000);
    chk(read_valid === 1'b1 && read_data === 16'h0100, "default read");
    @(negedge clk);
    chk(read_valid === 1'b0, "extra word");
    i_dacfz_host.send({1'b0, IDX_READ_CTRL, 8'h14});
    foreach (rows[i]) begin
      d = rows[i][15:8];
      i_dacfz_host.send({1'b0, IDX_AUDIO_CFG, d});
      chk({interp_rate_sel, rolloff_sel, clock_out_half_rate, clock_out_disable,
           audio_format_sel} === d, "config fields");
      i_dacfz_host.send(16'h8000);
      chk(read_data === {8'h14, d}, "config readback");
      // pin enable follows the disable bit one cycle later
      chk(clock_out_pin_oe === (rows[i][7:0] != 8'h00), "pin enable");
      tog = 0;
      repeat (8) begin
        p = clock_out_pin_o;
        @(negedge clk);
        tog += (clock_out_pin_o !== p);
      end
      if (rows[i][7:0] != 8'h00) chk(tog == rows[i][7:0], "clock rate");
    end
    i_dacfz_host.send({1'b0, IDX_READ_CTRL, 8'h95});
    i_dacfz_host.send(16'h8000);
    k = 1;
    for (t = 0; t < 40; t++) begin
      if (read_valid === 1'b1) begin
        chk(read_data[14:8] === 7'(k), "walk order");
        chk(read_busy === (k != 21), "walk busy");
        k++;
      end
      @(negedge clk);
    end
    chk(k == 22, "walk length");
    i_dacfz_host.send({1'b0, IDX_MODE_CTRL, 8'h00});
    frames(1023, 24'h000000);
    chk(left_zero_flag === 1'b0, "flag early");
    frames(1, 24'h000000);
    chk(left_zero_flag === 1'b1 && right_zero_flag === 1'b0, "zero flags");
    chk(left_zero_mute === 1'b0, "mute while off");
    i_dacfz_host.send({1'b0, IDX_MODE_CTRL, 8'h10});
    @(negedge clk);
    chk(left_zero_mute === 1'b1 && right_zero_mute === 1'b0, "zero mute");
    chk(left_zero_flag === 1'b1, "flag after mute on");
    frames(1, 24'h800000);
    chk(left_zero_flag === 1'b0 && left_zero_mute === 1'b0, "nonzero clears");
    frames(1023, 24'h000000);
    chk(left_zero_flag === 1'b0, "count restart");
    // mid-run reset must bring every written field back to its default
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk({audio_format_sel, rolloff_sel, interp_rate_sel, clock_out_half_rate,
         clock_out_disable, zero_mute_en, auto_inc_en} === 10'h000, "mid reset");
    chk(clock_out_pin_oe === 1'b1 && word_target_index === 7'h01, "mid reset pin");
    wrap_up();
  end
endmodule
